/* File: verilog/ddt_pkg.sv */
// constants, encoding tables and carrier types of the serial link transmit formatter
// assumes one device clock and register access over apb
package ddt_pkg;
	localparam int NLANE = 5;
	localparam int CGS_OCTETS = 16;
	localparam int WQ_DEPTH = 6;
	// register indices; the byte address is four times the index
	localparam logic [9:0] IDX_EMPH = 10'h040;
	localparam logic [9:0] IDX_DGC = 10'h200;
	localparam logic [9:0] IDX_LFC = 10'h201;
	localparam logic [9:0] IDX_LMC = 10'h202;
	localparam logic [9:0] IDX_STAT = 10'h203;
	// field positions
	localparam int EMPH_LSB = 0;
	localparam int GB_BIT = 4;
	localparam int DEC_LSB = 0;
	localparam int SCR_BIT = 7;
	localparam int KM1_LSB = 2;
	localparam int EN_BIT = 0;
	localparam int DDR_BIT = 1;
	localparam int P54_BIT = 2;
	localparam int TM_LSB = 4;
	// reset values
	localparam logic [7:0] EMPH_RST = 8'h04;
	localparam logic [7:0] DGC_RST = 8'h00;
	localparam logic [7:0] LFC_RST = 8'h7c;
	localparam logic [7:0] LMC_RST = 8'h02;
	// control and data characters
	localparam logic [7:0] K28_0 = 8'h1c;
	localparam logic [7:0] K28_3 = 8'h7c;
	localparam logic [7:0] K28_5 = 8'hbc;
	localparam logic [7:0] D21_5 = 8'hb5;
	localparam logic [15:0] TPAT_WORD = 16'hf0f0;
	localparam logic [5:0] K28_6B = 6'h0f;
	localparam logic [3:0] A7_4B = 4'h7;
	// 5b6b and 3b4b codes for negative running disparity, first bit sent at msb
	localparam logic [5:0] T6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
		6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
	localparam logic [3:0] T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
	typedef struct packed {
		logic [14:0] i;
		logic [14:0] q;
		logic ovr_first;
		logic ovr_second;
	} ddt_sample_t;
	typedef enum {TM_NORMAL, TM_PRBS7, TM_PRBS15, TM_PRBS23, TM_RAMP, TM_TRANSPORT, TM_D215, TM_K285,
		TM_ILA, TM_RPAT, TM_DIFF0, TM_DIFF1} ddt_tm_t;
	typedef enum {ST_OFF, ST_CGS, ST_DATA} ddt_state_t;
endpackage : ddt_pkg

/* File: verilog/ddt_link_tx.sv */
// serial link transmit formatter: packs complex samples into words, spreads them over lanes,
// scrambles, 8b10b encodes, offers test patterns; registers over apb
// assumes samples arrive on the device clock; one 10-bit code group per lane per clock
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
module ddt_link_tx #(
	parameter int NLANE = ddt_pkg::NLANE,
	parameter int CGS_OCTETS = ddt_pkg::CGS_OCTETS
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic smp_valid_i,
	input wire ddt_pkg::ddt_sample_t smp_i,
	output logic smp_ready_o,
	output wire logic [NLANE-1:0][9:0] lane_sym_o,
	output logic [NLANE-1:0] lane_on_o,
	output logic link_clk_en_o,
	output logic [1:0] rate_code_o,
	output logic [3:0] emph_o
);
	localparam int WQ = ddt_pkg::WQ_DEPTH;

	// lane count and octets per frame for a legal setting, zero lanes otherwise
	function automatic logic [7:0] lane_cfg(input logic [2:0] dec, input logic ddr, input logic p54);
		case ({dec, ddr, p54})
			5'h02: return {3'd5, 5'd4};
			5'h03: return {3'd4, 5'd2};
			5'h04: return {3'd5, 5'd4};
			5'h05: return {3'd4, 5'd2};
			5'h06: return {3'd3, 5'd8};
			5'h07: return {3'd2, 5'd2};
			5'h08: return {3'd4, 5'd2};
			5'h0a: return {3'd2, 5'd2};
			5'h0c: return {3'd3, 5'd8};
			5'h0d: return {3'd2, 5'd2};
			5'h0e: return {3'd2, 5'd16};
			5'h0f: return {3'd1, 5'd4};
			5'h10: return {3'd2, 5'd2};
			5'h12: return {3'd1, 5'd4};
			5'h14: return {3'd2, 5'd16};
			5'h15: return {3'd1, 5'd4};
			default: return 8'h00;
		endcase
	endfunction : lane_cfg

	// 8b10b encoder; returns new disparity above the code group
	function automatic logic [10:0] enc(input logic [7:0] d, input logic k, input logic rd);
		logic [5:0] s;
		logic [3:0] f;
		logic r1;
		s = k ? ddt_pkg::K28_6B : ddt_pkg::T6[d[4:0]];
		if (rd && ($countones(s) != 3 || s == 6'h38)) s = ~s;
		r1 = ($countones(s) == 3) ? rd : ~rd;
		f = ddt_pkg::T4[d[7:5]];
		// alternate x.7 avoids a run of five equal bits
		if (d[7:5] == 3'h7 && !k && ((!r1 && s[1:0] == 2'h3) || (r1 && s[1:0] == 2'h0))) f = ddt_pkg::A7_4B;
		if (r1 && ($countones(f) != 2 || f == 4'hc)) f = ~f;
		// a control code at positive disparity is the full complement, balanced tail included
		if (k && !r1 && $countones(f) == 2 && f != 4'hc) f = ~f;
		return {($countones(f) == 2) ? r1 : ~r1, s, f};
	endfunction : enc

	// self-synchronous scrambler, msb first
	function automatic logic [22:0] scramble_on(input logic [7:0] d, input logic [14:0] st);
		logic o;
		for (int b = 7; b >= 0; b--) begin
			o = d[b] ^ st[14] ^ st[13];
			st = {st[13:0], o};
			d[b] = o;
		end
		return {st, d};
	endfunction : scramble_on

	logic [7:0] emph_q, dgc_q, lfc_q, lmc_q;
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic [9:0] idx;
	logic hit;
	logic [7:0] stat;
	logic [7:0] rd_mux;
	logic [7:0] cfg;
	logic [2:0] lanes;
	logic [4:0] fm1;
	logic en_q, scr_on;
	logic [1:0] rate_d;
	ddt_pkg::ddt_tm_t tm;
	ddt_pkg::ddt_state_t st_q;

	assign idx = paddr_i[11:2];
	assign cfg = lane_cfg(dgc_q[ddt_pkg::DEC_LSB +: 3], lmc_q[ddt_pkg::DDR_BIT], lmc_q[ddt_pkg::P54_BIT]);
	assign lanes = cfg[7:5];
	assign fm1 = cfg[4:0] - 5'd1;
	assign en_q = lmc_q[ddt_pkg::EN_BIT];
	assign scr_on = lfc_q[ddt_pkg::SCR_BIT];
	assign rate_d = {lmc_q[ddt_pkg::DDR_BIT], lmc_q[ddt_pkg::P54_BIT]};
	assign tm = ddt_pkg::ddt_tm_t'(lmc_q[ddt_pkg::TM_LSB +: 4]);
	assign stat = {2'h0, rate_d, st_q == ddt_pkg::ST_DATA, lanes};

	// address decode and read mux
	always_comb begin
		hit = paddr_i[1:0] == 2'h0;
		rd_mux = 8'h00;
		case (idx)
			ddt_pkg::IDX_EMPH: rd_mux = emph_q;
			ddt_pkg::IDX_DGC: rd_mux = dgc_q;
			ddt_pkg::IDX_LFC: rd_mux = lfc_q;
			ddt_pkg::IDX_LMC: rd_mux = lmc_q;
			ddt_pkg::IDX_STAT: rd_mux = stat;
			default: hit = 1'b0;
		endcase
	end

	// one wait state: pready rises on the second access cycle
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= psel_i && penable_i && !pready_q;
			if (psel_i && penable_i && !pready_q) begin
				prdata_q <= {24'h00_0000, rd_mux};
				pslverr_q <= !hit;
			end
		end
	end

	// writes land on the edge that completes the transfer
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			emph_q <= ddt_pkg::EMPH_RST;
			dgc_q <= ddt_pkg::DGC_RST;
			lfc_q <= ddt_pkg::LFC_RST;
			lmc_q <= ddt_pkg::LMC_RST;
		end else if (psel_i && penable_i && pready_q && pwrite_i && hit) begin
			case (idx)
				ddt_pkg::IDX_EMPH: emph_q <= pwdata_i[7:0];
				ddt_pkg::IDX_DGC: begin
					dgc_q[7:3] <= pwdata_i[7:3];
					if (pwdata_i[2:0] <= 3'h5) dgc_q[2:0] <= pwdata_i[2:0];
				end
				ddt_pkg::IDX_LFC: lfc_q <= pwdata_i[7:0];
				ddt_pkg::IDX_LMC: lmc_q <= pwdata_i[7:0];
				default: ;
			endcase
		end
	end

	// sample formatting with optional x2 final gain, saturating
	logic [14:0] iv, qv;
	logic [15:0] iw, qw;
	logic gb;
	assign gb = dgc_q[ddt_pkg::GB_BIT];
	always_comb begin
		iv = smp_i.i;
		qv = smp_i.q;
		if (gb) begin
			iv = (smp_i.i[14] != smp_i.i[13]) ? {smp_i.i[14], {14{~smp_i.i[14]}}} : {smp_i.i[13:0], 1'b0};
			qv = (smp_i.q[14] != smp_i.q[13]) ? {smp_i.q[14], {14{~smp_i.q[14]}}} : {smp_i.q[13:0], 1'b0};
		end
		iw = {iv, smp_i.ovr_first};
		qw = {qv, smp_i.ovr_second};
	end

	// word staging; lanes take whole words only
	logic [15:0] wq_q [WQ];
	logic [15:0] wq_d [WQ];
	logic [2:0] cnt_q, cnt_d;
	logic rdy_q, ph_q, pop, push;
	assign pop = ph_q && st_q != ddt_pkg::ST_OFF && lanes != 3'h0 && cnt_q >= lanes;
	assign push = smp_valid_i && rdy_q && en_q;
	always_comb begin
		int n;
		n = int'(cnt_q);
		wq_d = wq_q;
		if (pop) begin
			for (int j = 0; j < WQ; j++) wq_d[j] = (j + int'(lanes) < WQ) ? wq_q[j + int'(lanes)] : 16'h0000;
			n = n - int'(lanes);
		end
		if (push) begin
			for (int j = 0; j < WQ; j++) begin
				if (j == n) wq_d[j] = iw;
				if (j == n + 1) wq_d[j] = qw;
			end
			n = n + 2;
		end
		cnt_d = 3'(n);
	end

	// a disabled link drops samples so the filter chain never stalls
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !en_q) begin
			cnt_q <= 3'h0;
			rdy_q <= 1'b1;
			for (int j = 0; j < WQ; j++) wq_q[j] <= 16'h0000;
		end else begin
			cnt_q <= cnt_d;
			rdy_q <= cnt_d <= 3'(WQ - 2);
			wq_q <= wq_d;
		end
	end

	// link sequencing, frame and multiframe counting
	logic [15:0] cgs_q;
	logic [4:0] oct_q, frm_q;
	logic [7:0] ramp_q;
	logic mf_first, mf_last;
	assign mf_first = oct_q == 5'h00 && frm_q == 5'h00;
	assign mf_last = oct_q == fm1 && frm_q == lfc_q[ddt_pkg::KM1_LSB +: 5];
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !en_q) begin
			st_q <= ddt_pkg::ST_OFF;
			cgs_q <= 16'h0000;
			ph_q <= 1'b0;
			oct_q <= 5'h00;
			frm_q <= 5'h00;
			ramp_q <= 8'h00;
		end else begin
			ph_q <= ~ph_q;
			case (st_q)
				ddt_pkg::ST_OFF: if (lanes != 3'h0) st_q <= ddt_pkg::ST_CGS;
				ddt_pkg::ST_CGS: begin
					cgs_q <= cgs_q + 16'h0001;
					if (cgs_q == 16'(CGS_OCTETS - 1)) st_q <= ddt_pkg::ST_DATA;
				end
				ddt_pkg::ST_DATA: begin
					ramp_q <= ramp_q + 8'h01;
					oct_q <= (oct_q == fm1) ? 5'h00 : oct_q + 5'h01;
					if (mf_last) frm_q <= 5'h00;
					else if (oct_q == fm1) frm_q <= frm_q + 5'h01;
				end
				default: st_q <= ddt_pkg::ST_OFF;
			endcase
		end
	end

	// shared prbs generator, ten bits per clock
	logic [22:0] prbs_q, prbs_d;
	logic [9:0] pbits;
	always_comb begin
		logic fb;
		fb = 1'b0;
		prbs_d = prbs_q;
		pbits = 10'h000;
		for (int b = 9; b >= 0; b--) begin
			case (tm)
				ddt_pkg::TM_PRBS7: fb = prbs_d[6] ^ prbs_d[5];
				ddt_pkg::TM_PRBS15: fb = prbs_d[14] ^ prbs_d[13];
				default: fb = prbs_d[22] ^ prbs_d[17];
			endcase
			pbits[b] = fb;
			prbs_d = {prbs_d[21:0], fb};
		end
	end
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !en_q) prbs_q <= '1;
		else prbs_q <= prbs_d;
	end

	// per-lane octet choice, scrambling and encoding
	for (genvar l = 0; l < NLANE; l++) begin : g_lane
		logic [15:0] word_q;
		logic rd_q;
		logic [14:0] scr_q, sn;
		logic [9:0] sym_q, rawv;
		logic [7:0] oct, woct;
		logic [22:0] sres;
		logic [10:0] e;
		logic k, raw;
		always_comb begin
			woct = ph_q ? word_q[7:0] : word_q[15:8];
			sres = scramble_on(woct, scr_q);
			oct = woct;
			sn = scr_q;
			k = 1'b0;
			raw = 1'b0;
			rawv = 10'h000;
			case (tm)
				ddt_pkg::TM_NORMAL, ddt_pkg::TM_TRANSPORT: begin
					if (st_q != ddt_pkg::ST_DATA) begin
						oct = ddt_pkg::K28_5;
						k = 1'b1;
					end else if (scr_on) begin
						oct = sres[7:0];
						sn = sres[22:8];
					end
				end
				ddt_pkg::TM_PRBS7, ddt_pkg::TM_PRBS15, ddt_pkg::TM_PRBS23: begin
					raw = 1'b1;
					rawv = pbits;
				end
				ddt_pkg::TM_RAMP: oct = ramp_q;
				ddt_pkg::TM_D215: oct = ddt_pkg::D21_5;
				ddt_pkg::TM_K285: begin
					oct = ddt_pkg::K28_5;
					k = 1'b1;
				end
				ddt_pkg::TM_ILA: begin
					k = mf_first || mf_last;
					oct = mf_first ? ddt_pkg::K28_0 : (mf_last ? ddt_pkg::K28_3 : ramp_q);
				end
				ddt_pkg::TM_RPAT: oct = prbs_q[7:0];
				ddt_pkg::TM_DIFF0: raw = 1'b1;
				ddt_pkg::TM_DIFF1: begin
					raw = 1'b1;
					rawv = 10'h3ff;
				end
				default: ;
			endcase
			e = enc(oct, k, rd_q);
		end
		// a lane beyond the active count stays idle, low lanes go first
		always_ff @(posedge clk_i) begin
			if (!nrst_i || !en_q) begin
				rd_q <= 1'b0;
				scr_q <= 15'h0000;
				word_q <= 16'h0000;
				sym_q <= 10'h000;
			end else begin
				if (ph_q) word_q <= (tm == ddt_pkg::TM_TRANSPORT) ? ddt_pkg::TPAT_WORD ^ 16'(l)
					: ((pop && 3'(l) < lanes) ? wq_q[l] : 16'h0000);
				if (st_q == ddt_pkg::ST_OFF || 3'(l) >= lanes) sym_q <= 10'h000;
				else if (raw) sym_q <= rawv;
				else begin
					sym_q <= e[9:0];
					rd_q <= e[10];
					scr_q <= sn;
				end
			end
		end
		assign lane_sym_o[l] = sym_q;
	end

	// outputs toward the serializers and drivers
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			lane_on_o <= '0;
			link_clk_en_o <= 1'b0;
			rate_code_o <= 2'h0;
			emph_o <= 4'h0;
		end else begin
			for (int l = 0; l < NLANE; l++) lane_on_o[l] <= en_q && 3'(l) < lanes;
			link_clk_en_o <= en_q;
			rate_code_o <= rate_d;
			emph_o <= emph_q[ddt_pkg::EMPH_LSB +: 4];
		end
	end
	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign smp_ready_o = rdy_q;

	a_link_off_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!en_q |=> lane_on_o == '0 && lane_sym_o == '0 && !link_clk_en_o) else $error("lanes active while link off");
	a_low_lanes_first: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(lane_on_o & (lane_on_o + 1'b1)) == '0) else $error("active lanes not contiguous from lane 0");
	a_lane_limit: assert property (@(posedge clk_i) disable iff (!nrst_i)
		en_q |=> $countones(lane_on_o) == $past(lanes) && $past(lanes) <= 3'd5) else $error("lane count wrong");
	a_iword_pack: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!gb |-> iw == {smp_i.i, smp_i.ovr_first}) else $error("in-phase word misformatted");
	a_qword_pack: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!gb |-> qw == {smp_i.q, smp_i.ovr_second}) else $error("quadrature word misformatted");
	a_gain_double: assert property (@(posedge clk_i) disable iff (!nrst_i)
		gb && smp_i.i[14] == smp_i.i[13] |-> iw[15:1] == {smp_i.i[13:0], 1'b0}) else $error("boost gain wrong");
	a_rate_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$changed(rate_d) |=> rate_code_o == $past(rate_d)) else $error("rate code not updated");
	a_start_cgs: assert property (@(posedge clk_i) disable iff (!nrst_i)
		st_q == ddt_pkg::ST_OFF && en_q && lanes != 3'h0
		&& (tm == ddt_pkg::TM_NORMAL || tm == ddt_pkg::TM_TRANSPORT || tm == ddt_pkg::TM_K285)
		|=> st_q == ddt_pkg::ST_CGS ##1 lane_sym_o[0] == 10'h0fa)
		else $error("link did not start with K28.5");
	a_prbs_raw: assert property (@(posedge clk_i) disable iff (!nrst_i)
		st_q != ddt_pkg::ST_OFF && tm == ddt_pkg::TM_PRBS7 && lanes != 3'h0 && en_q ##1 en_q
		|-> lane_sym_o[0] == $past(pbits)) else $error("prbs bits not sent raw");
	a_d215_out: assert property (@(posedge clk_i) disable iff (!nrst_i)
		st_q != ddt_pkg::ST_OFF && tm == ddt_pkg::TM_D215 && lanes != 3'h0 && en_q ##1 en_q
		|-> lane_sym_o[0] == 10'h2aa) else $error("D21.5 pattern wrong");
endmodule : ddt_link_tx

/* File: bench/ddt_rx_model.sv */
// far-end receiver model: decodes 8b10b lanes, counts commas on lane 0, keeps first data word per lane
// assumes one code group per lane per clock, first bit at [9]; a powered-down lane clears its capture flags but keeps its word
`timescale 1ns/100ps
module ddt_rx_model #(
	parameter int NLANE = 5
) (
	input wire logic clk_i,
	input wire logic [NLANE-1:0][9:0] lane_sym_i,
	input wire logic [NLANE-1:0] lane_on_i,
	output logic [15:0] commas_o,
	output logic [NLANE-1:0][15:0] word_o,
	output logic [NLANE-1:0] got_o
);
	logic [NLANE-1:0] half_q;
	logic [NLANE-1:0] kc;
	// table search; exact match wins because balanced codes collide with complements
	function automatic logic [7:0] dec8(input logic [9:0] s);
		logic [7:0] r;
		r = 8'h00;
		for (int x = 0; x < 32; x++) if (s[9:4] == ~ddt_pkg::T6[x]) r[4:0] = 5'(x);
		for (int x = 0; x < 32; x++) if (s[9:4] == ddt_pkg::T6[x]) r[4:0] = 5'(x);
		for (int y = 0; y < 8; y++) if (s[3:0] == ~ddt_pkg::T4[y]) r[7:5] = 3'(y);
		for (int y = 0; y < 8; y++) if (s[3:0] == ddt_pkg::T4[y]) r[7:5] = 3'(y);
		if (s[3:0] == ddt_pkg::A7_4B || s[3:0] == ~ddt_pkg::A7_4B) r[7:5] = 3'h7;
		return r;
	endfunction : dec8
	// control characters of either disparity
	always_comb begin
		for (int l = 0; l < NLANE; l++) kc[l] = lane_sym_i[l][9:4] == ddt_pkg::K28_6B || lane_sym_i[l][9:4] == ~ddt_pkg::K28_6B;
	end
	// comma count of the synchronisation phase
	always_ff @(posedge clk_i) begin
		if (!lane_on_i[0]) begin
			commas_o <= 16'h0000;
		end else if (kc[0]) begin
			commas_o <= commas_o + 16'h0001;
		end
	end
	// first nonzero data octet opens a word, the next one closes it
	always_ff @(posedge clk_i) begin
		for (int l = 0; l < NLANE; l++) begin
			if (!lane_on_i[l]) begin
				got_o[l] <= 1'b0;
				half_q[l] <= 1'b0;
			end else if (!got_o[l] && !kc[l] && (half_q[l] || dec8(lane_sym_i[l]) != 8'h00)) begin
				word_o[l] <= {word_o[l][7:0], dec8(lane_sym_i[l])};
				half_q[l] <= 1'b1;
				got_o[l] <= half_q[l];
			end
		end
	end
endmodule : ddt_rx_model

/* File: bench/tb.sv */
// top testbench: apb register checks, every link configuration, test patterns, sample transport
// assumes the package and design are compiled first; the receiver model watches the lanes
`timescale 1ns/100ps
module tb;
	localparam int CGS = 2; // shortened comma phase keeps the run brief
	localparam logic [11:0] A_EMPH = {ddt_pkg::IDX_EMPH, 2'b00};
	localparam logic [11:0] A_DGC = {ddt_pkg::IDX_DGC, 2'b00};
	localparam logic [11:0] A_LFC = {ddt_pkg::IDX_LFC, 2'b00};
	localparam logic [11:0] A_LMC = {ddt_pkg::IDX_LMC, 2'b00};
	localparam logic [11:0] A_STAT = {ddt_pkg::IDX_STAT, 2'b00};
	// {decimation code, double rate, five quarters, lanes}; last entry is an illegal pairing
	localparam logic [7:0] CFG [17] = '{8'h15, 8'h1c, 8'h25, 8'h2c, 8'h33, 8'h3a, 8'h44, 8'h52, 8'h63,
		8'h6a, 8'h72, 8'h79, 8'h82, 8'h91, 8'ha2, 8'ha9, 8'h48};
	logic clk_i, nrst_i, psel, penable, pwrite, pready, pslverr, smp_valid, smp_ready, clk_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	ddt_pkg::ddt_sample_t smp;
	logic [4:0][9:0] sym;
	logic [4:0][15:0] word;
	logic [4:0] lane_on, got;
	logic [1:0] rate;
	logic [3:0] emph;
	logic [15:0] commas;
	logic [9:0] s;
	logic [7:0] rd;
	logic err;
	int n, t;
	int num_errors = 0;
	int comparisons = 0;

	ddt_link_tx #(.NLANE(5), .CGS_OCTETS(CGS)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .smp_valid_i(smp_valid), .smp_i(smp), .smp_ready_o(smp_ready),
		.lane_sym_o(sym), .lane_on_o(lane_on), .link_clk_en_o(clk_en), .rate_code_o(rate), .emph_o(emph));
	ddt_rx_model #(.NLANE(5)) rx_u (.clk_i(clk_i), .lane_sym_i(sym), .lane_on_i(lane_on), .commas_o(commas),
		.word_o(word), .got_o(got));

	// 50 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task automatic report_and_stop();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic cycles(input int c);
		repeat (c) @(posedge clk_i);
	endtask : cycles

	// one apb transfer; request held until pready is sampled high, then an idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, wd};
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk("pready", 1, pready);
		if (pready !== 1'b1) report_and_stop();
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask : apb

	task automatic wreg(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wreg

	task automatic rreg(input logic [11:0] a, input logic [7:0] e, input logic ee);
		apb(1'b0, a, 8'h00);
		chk("pslverr", ee, err);
		if (!ee) chk($sformatf("reg %h", a), e, rd);
	endtask : rreg

	// software order: enable cleared, settings written, enable set last
	task automatic link(input logic [7:0] dgc, input logic [7:0] ctl);
		wreg(A_LMC, ctl & 8'hfe);
		wreg(A_DGC, dgc);
		wreg(A_LMC, ctl);
		cycles(30);
	endtask : link

	// bounds the whole run
	initial begin
		cycles(100000);
		num_errors++;
		$display("[ERR] run length expected end seen limit");
		report_and_stop();
	end

	initial begin
		nrst_i <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 12'h000;
		pwdata <= 32'h0;
		smp_valid <= 1'b0;
		smp <= '0;
		cycles(16);
		nrst_i <= 1'b1;
		cycles(4);
		chk("emph_o", 4'h4, emph);
		chk("lane_on_o", 0, lane_on);
		chk("link_clk_en_o", 0, clk_en);
		chk("smp_ready_o", 1, smp_ready);
		rreg(A_EMPH, 8'h04, 1'b0);
		rreg(A_DGC, 8'h00, 1'b0);
		rreg(A_LFC, 8'h7c, 1'b0);
		rreg(A_LMC, 8'h02, 1'b0);
		rreg(12'h004, 8'h00, 1'b1);
		rreg(12'h101, 8'h00, 1'b1);
		wreg(A_EMPH, 8'h0b);
		rreg(A_EMPH, 8'h0b, 1'b0);
		cycles(2);
		chk("emph_o", 4'hb, emph);
		wreg(A_DGC, 8'h17);
		rreg(A_DGC, 8'h10, 1'b0);
		wreg(A_LFC, 8'hfc);
		rreg(A_LFC, 8'hfc, 1'b0);
		wreg(A_LFC, 8'h7c);
		// every decimation and rate pairing, then an illegal one
		foreach (CFG[k]) begin
			link({5'h0, CFG[k][7:5]}, {5'h0, CFG[k][3], CFG[k][4], 1'b1});
			chk("lane_on_o", 5'h1f >> (3'd5 - CFG[k][2:0]), lane_on);
			chk("rate_code_o", {CFG[k][4], CFG[k][3]}, rate);
			chk("link_clk_en_o", 1, clk_en);
			chk("commas", (CFG[k][2:0] != 3'd0) ? CGS : 0, commas);
			rreg(A_STAT, {2'b0, CFG[k][4], CFG[k][3], CFG[k][2:0] != 3'd0, CFG[k][2:0]}, 1'b0);
		end
		wreg(A_LMC, 8'h00);
		cycles(3);
		chk("lane_on_o", 0, lane_on);
		chk("link_clk_en_o", 0, clk_en);
		chk("lane_sym_o", 0, sym != '0);
		chk("smp_ready_o", 1, smp_ready);
		// every test mode on five lanes
		for (int m = 0; m < 12; m++) begin
			link(8'h01, {m[3:0], 4'h1});
			s = sym[0];
			chk("lane_on_o", 5'h1f, lane_on);
			if (m == 6 || m > 9) chk("pattern", (m == 6) ? 10'h2aa : (m == 10) ? 10'h000 : 10'h3ff, s);
			if (m == 7) chk("k28_5", 1, s == 10'h0fa || s == 10'h305);
			if (m != 5) chk("lane4", s, sym[4]);
			if (m >= 1 && m <= 3) chk("prbs lanes", sym[0], sym[4]);
			if (m == 1) cycles(127);
			if (m == 1) chk("prbs7 period", s, sym[0]);
		end
		// three samples fill five lanes with I,Q,I,Q,I; second pass with gain boost
		for (int g = 0; g < 2; g++) begin
			link({3'h0, g[0], 4'h1}, 8'h01);
			smp <= '{i: 15'h1234, q: 15'h0abc, ovr_first: 1'b1, ovr_second: 1'b0};
			smp_valid <= 1'b1;
			n = 0;
			t = 0;
			while (n < 3 && t < 50) begin
				@(posedge clk_i);
				t++;
				if (smp_ready === 1'b1) n++;
			end
			smp_valid <= 1'b0;
			chk("samples taken", 3, n);
			cycles(20);
			chk("words", 5'h1f, got);
			for (int l = 0; l < 5; l++) begin
				chk("lane word", l % 2 ? (g ? 16'h2af0 : 16'h1578) : (g ? 16'h48d1 : 16'h2469), word[l]);
			end
		end
		report_and_stop();
	end
endmodule : tb
